// ==== rtl/cesup_defs.svh ====
// constants for the communication error supervisor
// assumes a 200 MHz clock and settings in 0.1 s units
`ifndef CESUP_DEFS_SVH
`define CESUP_DEFS_SVH

// -----------------------------------------------------------
// timing
// -----------------------------------------------------------
`define CESUP_CLK_HZ 200000000
`define CESUP_TICK_MS 100
`define CESUP_TICK_CYCLES ((`CESUP_CLK_HZ / 1000) * `CESUP_TICK_MS)

// -----------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------
`define CESUP_OFF_CTRL 12'h000
`define CESUP_OFF_RETRY 12'h004
`define CESUP_OFF_INTERVAL 12'h008
`define CESUP_OFF_STATUS 12'h00c
`define CESUP_OFF_IRQ_STAT 12'h010
`define CESUP_OFF_IRQ_MASK 12'h014
`define CESUP_OFF_OUT_FUNC 12'h018

// -----------------------------------------------------------
// fields and values
// -----------------------------------------------------------
`define CESUP_DISABLED 16'h270f
`define CESUP_RETRY_MAX 16'h000a
`define CESUP_RETRY_RST 16'h0001
`define CESUP_INTERVAL_MAX 16'h270e
`define CESUP_FUNC_ALARM_HI 8'h62
`define CESUP_FUNC_ALARM_LO 8'hc6
`define CESUP_CTRL_MODBUS 0
`define CESUP_CTRL_LINK_MODE 1
`define CESUP_CTRL_FAULT_CLR 2
`define CESUP_CTRL_STOP_LSB 4
`define CESUP_IRQ_TRIP 0
`define CESUP_IRQ_ALARM 1
`define CESUP_IRQ_LOSS 2

`endif

// ==== rtl/cesup_pkg.sv ====
// types shared by the supervisor files
// assumes cesup_defs.svh holds the numeric constants
package cesup_pkg;
	typedef enum logic [1:0] {
		CESUP_STOP_COAST,
		CESUP_STOP_DECEL,
		CESUP_STOP_DECEL_RESTART,
		CESUP_STOP_RSVD
	} cesup_stop_t;

	typedef enum logic [1:0] {
		CESUP_ST_RUN,
		CESUP_ST_DECEL,
		CESUP_ST_TRIPPED,
		CESUP_ST_COASTED
	} cesup_state_t;
endpackage

// ==== rtl/cesup_tick.sv ====
// 0.1 s tick generator for the signal-loss timer
// assumes one clock; ce_in freezes the divider
`timescale 1ns/1ps
`include "cesup_defs.svh"

module cesup_tick #(
	parameter int unsigned TICK_CYCLES = `CESUP_TICK_CYCLES
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic clr_in,
	output logic tick_out
);
	logic [31:0] cnt_q;

	always_ff @(posedge clk_in) begin
		if (srst_in || (ce_in && clr_in)) begin
			cnt_q <= 32'h0;
			tick_out <= 1'b0;
		end else if (ce_in) begin
			if (cnt_q >= TICK_CYCLES - 1) begin
				cnt_q <= 32'h0;
				tick_out <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 32'h1;
				tick_out <= 1'b0;
			end
		end
	end
endmodule // cesup_tick

// ==== rtl/cesup_top.sv ====
// communication error supervisor for a half-duplex serial link
// assumes frame decoding elsewhere gives one-cycle frame pulses
//
// What this block does
// - retry limit 0..10, default 1, 9999 alarm
// - errors beyond limit trip, stop per mode
// - limit 9999 gives alarm, never trip
// - alarm on terminal, function 98 or 198
// - retry limit ignored under Modbus protocol
// - loss interval 0.1..999.8 s trips on silence
// - interval 9999 disables loss detection
// - interval 0 trips on entering link mode
// - any received frame clears loss counter
// - loss check starts at first link-mode frame
// - stop modes coast, decel+fault, decel+restart
// - mode 2 restart resumes prior commands
`timescale 1ns/1ps
`include "cesup_defs.svh"

module cesup_top #(
	parameter int unsigned TICK_CYCLES = `CESUP_TICK_CYCLES
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// frame events from the receiver, same clock
	input wire logic frame_ok_in,
	input wire logic frame_err_in,
	input wire logic decel_done_in,
	input wire logic run_cmd_in,
	input wire logic [15:0] speed_cmd_in,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [11:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// drive side
	output logic coast_out,
	output logic decel_out,
	output logic fault_out,
	output logic trip_display_out,
	output logic run_cmd_out,
	output logic [15:0] speed_cmd_out,
	output logic alarm_term_a_out,
	output logic alarm_term_b_out,
	output logic alarm_term_c_out,
	output logic irq_out
);
	import cesup_pkg::*;

	// -----------------------------------------------------------
	// settings
	// -----------------------------------------------------------
	logic modbus_q;
	logic link_mode_q;
	cesup_stop_t stop_q;
	logic [15:0] retry_limit_q;
	logic [15:0] interval_q;
	logic [7:0] func_a_q;
	logic [7:0] func_b_q;
	logic [7:0] func_c_q;
	logic [2:0] irq_mask_q;
	logic [2:0] irq_stat_q;
	logic fault_clr_q;

	// -----------------------------------------------------------
	// supervision state
	// -----------------------------------------------------------
	logic [15:0] err_cnt_q;
	logic [15:0] loss_cnt_q;
	logic loss_armed_q;
	logic link_mode_prev_q;
	logic alarm_q;
	logic fault_active_q;
	cesup_state_t state_q;
	logic run_hold_q;
	logic [15:0] speed_hold_q;
	logic tick;

	// -----------------------------------------------------------
	// axi4-lite handshake
	// -----------------------------------------------------------
	logic aw_hold_q;
	logic w_hold_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic rd_go;
	logic stat_rd;

	assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid_out;
	assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
	assign stat_rd = rd_go && (s_axi_araddr_in == `CESUP_OFF_IRQ_STAT);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 12'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= 2'h0;
		end else if (ce_in) begin
			s_axi_awready_out <= !aw_hold_q && !s_axi_awready_out;
			s_axi_wready_out <= !w_hold_q && !s_axi_wready_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (awaddr_q > `CESUP_OFF_OUT_FUNC)
					? 2'h2 : 2'h0;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------
	// register writes
	// -----------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			modbus_q <= 1'b0;
			link_mode_q <= 1'b0;
			stop_q <= CESUP_STOP_COAST;
			retry_limit_q <= `CESUP_RETRY_RST;
			interval_q <= `CESUP_DISABLED;
			func_a_q <= 8'h0;
			func_b_q <= 8'h0;
			func_c_q <= 8'h0;
			irq_mask_q <= 3'h0;
			fault_clr_q <= 1'b0;
		end else if (ce_in) begin
			fault_clr_q <= 1'b0;
			if (wr_go && wstrb_q[0]) begin
				case (awaddr_q)
					`CESUP_OFF_CTRL: begin
						modbus_q <= wdata_q[`CESUP_CTRL_MODBUS];
						link_mode_q <= wdata_q[`CESUP_CTRL_LINK_MODE];
						fault_clr_q <= wdata_q[`CESUP_CTRL_FAULT_CLR];
						stop_q <= cesup_stop_t'(
							wdata_q[`CESUP_CTRL_STOP_LSB +: 2]);
					end
					`CESUP_OFF_RETRY: begin
						if (wstrb_q[1] && (wdata_q[15:0] <= `CESUP_RETRY_MAX
							|| wdata_q[15:0] == `CESUP_DISABLED)) begin
							retry_limit_q <= wdata_q[15:0];
						end
					end
					`CESUP_OFF_INTERVAL: begin
						if (wstrb_q[1] && wdata_q[15:0] <= `CESUP_DISABLED) begin
							interval_q <= wdata_q[15:0];
						end
					end
					`CESUP_OFF_IRQ_MASK: irq_mask_q <= wdata_q[2:0];
					`CESUP_OFF_OUT_FUNC: begin
						func_a_q <= wdata_q[7:0];
						if (wstrb_q[1]) func_b_q <= wdata_q[15:8];
						if (wstrb_q[2]) func_c_q <= wdata_q[23:16];
					end
					default: ;
				endcase
			end
		end
	end

	// -----------------------------------------------------------
	// register reads
	// -----------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0;
			s_axi_rresp_out <= 2'h0;
		end else if (ce_in) begin
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
			if (rd_go) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rresp_out <= 2'h0;
				case (s_axi_araddr_in)
					`CESUP_OFF_CTRL: s_axi_rdata_out <= {26'h0, stop_q,
						2'h0, link_mode_q, modbus_q};
					`CESUP_OFF_RETRY: s_axi_rdata_out <= {16'h0, retry_limit_q};
					`CESUP_OFF_INTERVAL: s_axi_rdata_out <= {16'h0, interval_q};
					`CESUP_OFF_STATUS: s_axi_rdata_out <= {err_cnt_q[7:0],
						loss_cnt_q[15:0], 2'h0, loss_armed_q, alarm_q,
						fault_active_q, 1'b0, state_q};
					`CESUP_OFF_IRQ_STAT: s_axi_rdata_out <= {29'h0, irq_stat_q};
					`CESUP_OFF_IRQ_MASK: s_axi_rdata_out <= {29'h0, irq_mask_q};
					`CESUP_OFF_OUT_FUNC: s_axi_rdata_out <= {8'h0, func_c_q,
						func_b_q, func_a_q};
					default: begin
						s_axi_rdata_out <= 32'h0;
						s_axi_rresp_out <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------
	// receive error counting
	// -----------------------------------------------------------
	logic retry_active;
	logic retry_trip;
	logic retry_alarm;
	// only under the ascii link protocol
	assign retry_active = !modbus_q && frame_err_in;
	// run of errors beyond the limit
	assign retry_trip = retry_active && retry_limit_q != `CESUP_DISABLED
		&& err_cnt_q >= retry_limit_q;
	assign retry_alarm = retry_active && retry_limit_q == `CESUP_DISABLED;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			err_cnt_q <= 16'h0;
			alarm_q <= 1'b0;
		end else if (ce_in) begin
			if (frame_ok_in || modbus_q) begin
				err_cnt_q <= 16'h0;
			end else if (retry_active && err_cnt_q != 16'hffff) begin
				err_cnt_q <= err_cnt_q + 16'h1;
			end
			if (retry_alarm) begin
				alarm_q <= 1'b1;
			end else if (frame_ok_in || retry_limit_q != `CESUP_DISABLED) begin
				alarm_q <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------
	// signal loss timer
	// -----------------------------------------------------------
	logic any_frame;
	logic loss_trip;
	logic mode_entry;
	assign any_frame = frame_ok_in || frame_err_in;
	assign mode_entry = link_mode_q && !link_mode_prev_q;

	cesup_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.clr_in(any_frame),
		.tick_out(tick)
	);

	// zero interval trips on mode entry
	assign loss_trip = link_mode_q && interval_q != `CESUP_DISABLED
		&& ((interval_q == 16'h0 && mode_entry)
		|| (interval_q != 16'h0 && loss_armed_q && tick
		&& loss_cnt_q >= interval_q));

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			loss_cnt_q <= 16'h0;
			loss_armed_q <= 1'b0;
			link_mode_prev_q <= 1'b0;
		end else if (ce_in) begin
			link_mode_prev_q <= link_mode_q;
			// arm at first frame in link mode
			if (!link_mode_q || interval_q == `CESUP_DISABLED) begin
				loss_armed_q <= 1'b0;
			end else if (any_frame) begin
				loss_armed_q <= 1'b1;
			end
			if (any_frame || !loss_armed_q) begin
				loss_cnt_q <= 16'h0;
			end else if (tick && loss_cnt_q != 16'hffff) begin
				loss_cnt_q <= loss_cnt_q + 16'h1;
			end
		end
	end

	// -----------------------------------------------------------
	// stop sequence
	// -----------------------------------------------------------
	logic comm_fault;
	assign comm_fault = retry_trip || loss_trip;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= CESUP_ST_RUN;
			fault_active_q <= 1'b0;
		end else if (ce_in) begin
			case (state_q)
				CESUP_ST_RUN: begin
					if (comm_fault) begin
						fault_active_q <= 1'b1;
						state_q <= (stop_q == CESUP_STOP_COAST
							|| stop_q == CESUP_STOP_RSVD)
							? CESUP_ST_COASTED : CESUP_ST_DECEL;
					end
				end
				CESUP_ST_DECEL: begin
					if (comm_fault) begin
						fault_active_q <= 1'b1;
					end else if (stop_q == CESUP_STOP_DECEL_RESTART
						&& any_frame) begin
						fault_active_q <= 1'b0;
						state_q <= CESUP_ST_RUN;
					end else if (decel_done_in) begin
						state_q <= CESUP_ST_TRIPPED;
					end
				end
				CESUP_ST_TRIPPED: begin
					if (stop_q == CESUP_STOP_DECEL_RESTART && !comm_fault
						&& any_frame) begin
						fault_active_q <= 1'b0;
						state_q <= CESUP_ST_RUN;
					end else if (fault_clr_q) begin
						fault_active_q <= 1'b0;
						state_q <= CESUP_ST_RUN;
					end
				end
				CESUP_ST_COASTED: begin
					if (fault_clr_q) begin
						fault_active_q <= 1'b0;
						state_q <= CESUP_ST_RUN;
					end
				end
				default: state_q <= CESUP_ST_RUN;
			endcase
		end
	end

	// -----------------------------------------------------------
	// drive outputs
	// -----------------------------------------------------------
	logic restart_mode;
	logic restart_evt;
	logic resume_q;
	assign restart_mode = stop_q == CESUP_STOP_DECEL_RESTART;
	// same condition that lets the stop sequence leave a stop
	assign restart_evt = restart_mode && !comm_fault && any_frame
		&& (state_q == CESUP_ST_DECEL
		|| state_q == CESUP_ST_TRIPPED);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			coast_out <= 1'b0;
			decel_out <= 1'b0;
			fault_out <= 1'b0;
			trip_display_out <= 1'b0;
			run_cmd_out <= 1'b0;
			speed_cmd_out <= 16'h0;
			run_hold_q <= 1'b0;
			speed_hold_q <= 16'h0;
			resume_q <= 1'b0;
		end else if (ce_in) begin
			// pre-fault commands stand until a newer frame
			if (restart_evt) begin
				resume_q <= 1'b1;
			end else if (state_q == CESUP_ST_RUN && any_frame) begin
				resume_q <= 1'b0;
			end
			coast_out <= state_q == CESUP_ST_COASTED;
			decel_out <= state_q == CESUP_ST_DECEL;
			// fault at once or after stop
			fault_out <= state_q == CESUP_ST_COASTED
				|| (state_q == CESUP_ST_TRIPPED && !restart_mode);
			trip_display_out <= state_q == CESUP_ST_COASTED
				|| state_q == CESUP_ST_TRIPPED;
			// hold commands from before the fault
			if (state_q == CESUP_ST_RUN && !comm_fault && !resume_q) begin
				run_hold_q <= run_cmd_in;
				speed_hold_q <= speed_cmd_in;
				run_cmd_out <= run_cmd_in;
				speed_cmd_out <= speed_cmd_in;
			end else if (state_q == CESUP_ST_RUN) begin
				run_cmd_out <= run_hold_q;
				speed_cmd_out <= speed_hold_q;
			end else begin
				run_cmd_out <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------
	// alarm terminals and interrupt
	// -----------------------------------------------------------
	logic [2:0] term_q;
	logic [2:0] irq_evt;
	assign irq_evt = {loss_trip, retry_alarm, retry_trip};

	generate
		for (genvar i = 0; i < 3; i++) begin : g_term
			logic [7:0] fsel;
			assign fsel = (i == 0) ? func_a_q : (i == 1) ? func_b_q : func_c_q;
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					term_q[i] <= 1'b0;
				end else if (ce_in) begin
					term_q[i] <= (fsel == `CESUP_FUNC_ALARM_HI) ? alarm_q
						: (fsel == `CESUP_FUNC_ALARM_LO) ? !alarm_q : 1'b0;
				end
			end
		end
	endgenerate

	assign alarm_term_a_out = term_q[0];
	assign alarm_term_b_out = term_q[1];
	assign alarm_term_c_out = term_q[2];

	// set beats the read-clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_stat_q <= 3'h0;
			irq_out <= 1'b0;
		end else if (ce_in) begin
			irq_stat_q <= (stat_rd ? 3'h0 : irq_stat_q) | irq_evt;
			irq_out <= |(((stat_rd ? 3'h0 : irq_stat_q) | irq_evt)
				& irq_mask_q);
		end
	end
endmodule // cesup_top

// ==== testbench/cesup_checker.sv ====
// port assertions for the communication error supervisor
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module cesup_checker (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic coast_out,
	input wire logic decel_out,
	input wire logic fault_out,
	input wire logic trip_display_out,
	input wire logic run_cmd_out,
	input wire logic [15:0] speed_cmd_out
);
	// -----------------------------------------------------------
	// cycles since the last accepted write
	// -----------------------------------------------------------
	logic [2:0] wr_age_q;

	// coast and fault outputs only drop within 4 cycles of an accepted write
	always_ff @(posedge clk_in) begin
		if (srst_in || (s_axi_wvalid_in && s_axi_wready_out))
			wr_age_q <= 3'h0;
		else if (wr_age_q != 3'h7)
			wr_age_q <= wr_age_q + 3'h1;
	end

	property p_coast_no_run;
		@(posedge clk_in) disable iff (srst_in) coast_out |-> !run_cmd_out;
	endproperty
	a_coast_no_run: assert property (p_coast_no_run)
		else $error("run command while coasting");
	property p_decel_no_run;
		@(posedge clk_in) disable iff (srst_in) decel_out |-> !run_cmd_out;
	endproperty
	a_decel_no_run: assert property (p_decel_no_run)
		else $error("run command while decelerating");
	property p_stop_excl;
		@(posedge clk_in) disable iff (srst_in) !(coast_out && decel_out);
	endproperty
	a_stop_excl: assert property (p_stop_excl)
		else $error("coast and decel together");
	property p_fault_disp;
		@(posedge clk_in) disable iff (srst_in) fault_out |-> trip_display_out;
	endproperty
	a_fault_disp: assert property (p_fault_disp)
		else $error("fault output without trip display");
	property p_fault_after_stop;
		@(posedge clk_in) disable iff (srst_in) fault_out |-> !decel_out;
	endproperty
	a_fault_after_stop: assert property (p_fault_after_stop)
		else $error("fault output during deceleration");
	property p_fault_kept;
		@(posedge clk_in) disable iff (srst_in)
			$fell(fault_out) && !$past(srst_in) |-> wr_age_q < 3'h4;
	endproperty
	a_fault_kept: assert property (p_fault_kept)
		else $error("fault output dropped without clear");
	property p_coast_kept;
		@(posedge clk_in) disable iff (srst_in)
			$fell(coast_out) && !$past(srst_in) |-> wr_age_q < 3'h4;
	endproperty
	a_coast_kept: assert property (p_coast_kept)
		else $error("coast left without clear");
	property p_speed_hold;
		@(posedge clk_in) disable iff (srst_in)
			decel_out && $past(decel_out) |-> $stable(speed_cmd_out);
	endproperty
	a_speed_hold: assert property (p_speed_hold)
		else $error("speed command moved while stopping");
	property p_bresp_hold;
		@(posedge clk_in) disable iff (srst_in)
			s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
	endproperty
	a_bresp_hold: assert property (p_bresp_hold)
		else $error("write response dropped early");
endmodule // cesup_checker

bind cesup_top cesup_checker i_cesup_checker (.*);

// ==== testbench/cesup_host.sv ====
// host model: master on the serial link, sends frames
// assumes the bench calls send and drives keep_in
`timescale 1ns/1ps

module cesup_host #(
	parameter int PERIOD = 15
) (
	input wire logic clk_in,
	input wire logic keep_in,
	output logic frame_ok_out,
	output logic frame_err_out
);
	logic ok_q;
	logic err_q;
	logic ka_q;
	int cnt_q;

	initial begin
		ok_q = 1'b0;
		err_q = 1'b0;
		ka_q = 1'b0;
		cnt_q = 0;
	end

	assign frame_ok_out = ok_q | ka_q;
	assign frame_err_out = err_q;

	always @(posedge clk_in) begin
		ka_q <= keep_in && (cnt_q == PERIOD - 1);
		cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
	end

	task send(input logic err);
		@(posedge clk_in);
		ok_q <= !err;
		err_q <= err;
		@(posedge clk_in);
		ok_q <= 1'b0;
		err_q <= 1'b0;
	endtask
endmodule // cesup_host

// ==== testbench/cesup_bench.sv ====
// self-checking bench for the communication error supervisor
// assumes the host model and a shortened loss tick
`timescale 1ns/1ps
`include "cesup_defs.svh"
`define CHK(a, b, m) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("wrong value at %0t: %s", $time, m); \
	end \
end

module cesup_bench;
	logic clk_in, srst_in, ce_in, frame_ok_in, frame_err_in, keep;
	logic decel_done_in, run_cmd_in;
	logic [15:0] speed_cmd_in, speed_cmd_out;
	logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_rready_in, s_axi_rvalid_out;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, wr_resp;
	logic coast_out, decel_out, fault_out, trip_display_out, run_cmd_out;
	logic alarm_term_a_out, alarm_term_b_out, alarm_term_c_out, irq_out;
	int n_errors, cmp_count;

	cesup_top #(.TICK_CYCLES(10)) i_cesup_top (.clk_in(clk_in),
		.srst_in(srst_in), .ce_in(ce_in), .frame_ok_in(frame_ok_in),
		.frame_err_in(frame_err_in), .decel_done_in(decel_done_in),
		.run_cmd_in(run_cmd_in), .speed_cmd_in(speed_cmd_in),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in), .coast_out(coast_out),
		.decel_out(decel_out), .fault_out(fault_out),
		.trip_display_out(trip_display_out),
		.run_cmd_out(run_cmd_out), .speed_cmd_out(speed_cmd_out),
		.alarm_term_a_out(alarm_term_a_out),
		.alarm_term_b_out(alarm_term_b_out),
		.alarm_term_c_out(alarm_term_c_out), .irq_out(irq_out));
	cesup_host i_cesup_host (.clk_in(clk_in), .keep_in(keep),
		.frame_ok_out(frame_ok_in), .frame_err_out(frame_err_in));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// -----------------------------------------------------------
	// bus and wait tasks
	// -----------------------------------------------------------
	task print_verdict;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task stop_hung;
		`CHK(1'b0, 1'b1, "no answer in time")
		print_verdict;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
			if (s_axi_bvalid_out) break;
		end
		wr_resp = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
		if (i == 64) stop_hung;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
			if (s_axi_rvalid_out) break;
		end
		s_axi_rready_in <= 1'b0;
		if (i == 64) stop_hung;
		`CHK(s_axi_rdata_out, d, "read data")
		`CHK(s_axi_rresp_out, r, "read response")
	endtask
	// a stop shows as coast or decel; fault comes with coast in the same cycle
	task await_stop;
		int i;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_in);
			if (coast_out || decel_out) break;
		end
		if (i == 100) stop_hung;
		cyc(1);
	endtask
	task pulse_done;
		decel_done_in <= 1'b1;
		cyc(1);
		decel_done_in <= 1'b0;
		cyc(3);
	endtask

	// -----------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------
	initial begin
		srst_in = 1'b1;
		ce_in = 1'b1;
		keep = 1'b0;
		decel_done_in = 1'b0;
		run_cmd_in = 1'b0;
		speed_cmd_in = 16'h0;
		s_axi_awaddr_in = 12'h0;
		s_axi_araddr_in = 12'h0;
		s_axi_wdata_in = 32'h0;
		s_axi_wstrb_in = 4'hf;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
		{s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
		n_errors = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk_in);
		srst_in <= 1'b0;
		cyc(2);
		rd(`CESUP_OFF_RETRY, 32'h1, 2'h0);
		rd(`CESUP_OFF_INTERVAL, 32'h270f, 2'h0);
		rd(12'h01c, 32'h0, 2'h2);
		wr(12'h01c, 32'h0);
		`CHK(wr_resp, 2'h2, "write response")
		wr(`CESUP_OFF_OUT_FUNC, 32'h62c662);
		wr(`CESUP_OFF_IRQ_MASK, 32'h7);
		wr(`CESUP_OFF_CTRL, 32'h2);
		run_cmd_in <= 1'b1;
		speed_cmd_in <= 16'h1234;
		cyc(2);
		`CHK({alarm_term_a_out, alarm_term_b_out, alarm_term_c_out},
			3'b010, "idle term")
		i_cesup_host.send(1'b1);
		i_cesup_host.send(1'b0);
		i_cesup_host.send(1'b1);
		cyc(4);
		`CHK(coast_out, 1'b0, "error run broken")
		ce_in <= 1'b0;
		i_cesup_host.send(1'b1);
		cyc(2);
		`CHK(coast_out, 1'b0, "frozen")
		ce_in <= 1'b1;
		i_cesup_host.send(1'b1);
		await_stop;
		`CHK({coast_out, fault_out, irq_out}, 3'h7, "retry trip")
		rd(`CESUP_OFF_IRQ_STAT, 32'h1, 2'h0);
		cyc(2);
		`CHK(irq_out, 1'b0, "status cleared")
		wr(`CESUP_OFF_CTRL, 32'h6);
		cyc(2);
		`CHK({coast_out, fault_out}, 2'b00, "fault clear")
		wr(`CESUP_OFF_CTRL, 32'h3);
		repeat (3) i_cesup_host.send(1'b1);
		cyc(4);
		`CHK({coast_out, decel_out}, 2'b00, "modbus errors")
		i_cesup_host.send(1'b0);
		wr(`CESUP_OFF_RETRY, 32'h270f);
		wr(`CESUP_OFF_IRQ_MASK, 32'h5);
		wr(`CESUP_OFF_CTRL, 32'h2);
		repeat (3) i_cesup_host.send(1'b1);
		cyc(4);
		`CHK({coast_out, fault_out, alarm_term_a_out, alarm_term_b_out,
			alarm_term_c_out, irq_out}, 6'b001010, "alarm only")
		rd(`CESUP_OFF_IRQ_STAT, 32'h2, 2'h0);
		i_cesup_host.send(1'b0);
		cyc(4);
		`CHK({alarm_term_a_out, alarm_term_b_out, alarm_term_c_out},
			3'b010, "alarm off")
		wr(`CESUP_OFF_IRQ_MASK, 32'h7);
		wr(`CESUP_OFF_RETRY, 32'hb);
		s_axi_wstrb_in <= 4'h1;
		wr(`CESUP_OFF_RETRY, 32'h5);
		s_axi_wstrb_in <= 4'hf;
		rd(`CESUP_OFF_RETRY, 32'h270f, 2'h0);
		wr(`CESUP_OFF_RETRY, 32'h0);
		wr(`CESUP_OFF_CTRL, 32'h12);
		i_cesup_host.send(1'b1);
		await_stop;
		`CHK({decel_out, fault_out, run_cmd_out}, 3'b100, "decel")
		pulse_done;
		`CHK({decel_out, fault_out}, 2'b01, "fault after stop")
		rd(`CESUP_OFF_IRQ_STAT, 32'h1, 2'h0);
		wr(`CESUP_OFF_CTRL, 32'h16);
		wr(`CESUP_OFF_RETRY, 32'h1);
		i_cesup_host.send(1'b0);
		// loss timer is only armed by a frame in link mode
		wr(`CESUP_OFF_CTRL, 32'h0);
		wr(`CESUP_OFF_INTERVAL, 32'h3);
		wr(`CESUP_OFF_CTRL, 32'h2);
		cyc(100);
		`CHK(coast_out, 1'b0, "unarmed")
		i_cesup_host.send(1'b0);
		keep <= 1'b1;
		cyc(200);
		`CHK(coast_out, 1'b0, "kept alive")
		keep <= 1'b0;
		await_stop;
		`CHK({coast_out, fault_out}, 2'b11, "loss trip")
		rd(`CESUP_OFF_IRQ_STAT, 32'h4, 2'h0);
		wr(`CESUP_OFF_INTERVAL, 32'h270f);
		wr(`CESUP_OFF_CTRL, 32'h6);
		cyc(100);
		`CHK(coast_out, 1'b0, "no loss check")
		wr(`CESUP_OFF_CTRL, 32'h0);
		wr(`CESUP_OFF_INTERVAL, 32'h0);
		wr(`CESUP_OFF_CTRL, 32'h2);
		await_stop;
		`CHK(fault_out, 1'b1, "zero interval")
		wr(`CESUP_OFF_INTERVAL, 32'h270f);
		wr(`CESUP_OFF_CTRL, 32'h6);
		wr(`CESUP_OFF_CTRL, 32'h22);
		i_cesup_host.send(1'b0);
		cyc(2);
		`CHK({run_cmd_out, speed_cmd_out}, 17'h11234, "pass")
		i_cesup_host.send(1'b1);
		i_cesup_host.send(1'b1);
		await_stop;
		run_cmd_in <= 1'b0;
		speed_cmd_in <= 16'h5555;
		`CHK({decel_out, fault_out, run_cmd_out}, 3'b100, "decel")
		pulse_done;
		i_cesup_host.send(1'b0);
		cyc(3);
		`CHK({decel_out, fault_out, run_cmd_out, speed_cmd_out},
			19'h11234, "restart")
		print_verdict;
	end
endmodule // cesup_bench
